//--- src/prbp_pkg.sv
package prbp_pkg;

  // Register byte offsets.
  localparam logic [11:0] PRBP_REG_CTRL      = 12'h000;
  localparam logic [11:0] PRBP_REG_RING_BASE = 12'h004;
  localparam logic [11:0] PRBP_REG_RING_SIZE = 12'h008;
  localparam logic [11:0] PRBP_REG_EVT_SUPP  = 12'h00C;
  localparam logic [11:0] PRBP_REG_DOORBELL  = 12'h010;
  localparam logic [11:0] PRBP_REG_STATUS    = 12'h014;
  localparam logic [11:0] PRBP_REG_LAST_DESC = 12'h018;
  localparam logic [11:0] PRBP_REG_LAST_ID   = 12'h01C;
  localparam logic [11:0] PRBP_REG_USED_CNT  = 12'h020;
  localparam logic [11:0] PRBP_REG_DRV_EVT   = 12'h024;
  localparam logic [11:0] PRBP_REG_SHM_BASE  = 12'h028;
  localparam logic [11:0] PRBP_REG_SHM_SIZE  = 12'h02C;
  localparam logic [11:0] PRBP_REG_NOTE_DATA = 12'h030;

  // Control register fields.
  localparam int PRBP_CTRL_ENABLE     = 0;
  localparam int PRBP_CTRL_NOTE_DATA  = 1;
  localparam int PRBP_CTRL_PACKED     = 2;

  // Descriptor flag word bit positions.
  localparam int PRBP_FLAG_NEXT       = 0;
  localparam int PRBP_FLAG_WRITABLE   = 1;
  localparam int PRBP_FLAG_AVAIL      = 7;
  localparam int PRBP_FLAG_USED       = 15;

  // Notification payload fields.
  localparam int PRBP_NOTE_WRAP       = 15;

  // Event suppression codes.
  localparam logic [1:0] PRBP_EVT_ENABLE  = 2'h0;
  localparam logic [1:0] PRBP_EVT_DISABLE = 2'h1;
  localparam logic [1:0] PRBP_EVT_DESC    = 2'h2;

  // Reset values.
  localparam logic [31:0] PRBP_RST_CTRL      = 32'h0000_0004;
  localparam logic [15:0] PRBP_RST_RING_SIZE = 16'h0010;
  localparam logic [31:0] PRBP_RST_ZERO      = 32'h0000_0000;

  // Shared memory region count and descriptor size in bytes.
  localparam int          PRBP_SHM_REGIONS   = 2;
  localparam logic [31:0] PRBP_DESC_BYTES    = 32'h0000_0010;
  localparam logic [31:0] PRBP_FLAGS_OFS     = 32'h0000_000C;

  // Memory read port words fetched per descriptor after the flags word.
  localparam logic [1:0]  PRBP_DESC_WORDS    = 2'h3;

  typedef enum logic [2:0] {
    PRBP_IDLE  = 3'b000,
    PRBP_POLL  = 3'b001,
    PRBP_FETCH = 3'b010,
    PRBP_WORK  = 3'b011,
    PRBP_USED  = 3'b100
  } prbp_state_t;

endpackage : prbp_pkg

//--- src/prbp_mem_if.sv
`timescale 1ns/1ps
interface prbp_mem_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;

  modport master (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );

  modport port (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );
endinterface : prbp_mem_if

//--- src/prbp_mem_port.sv
`timescale 1ns/1ps
module prbp_mem_port
  import prbp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  prbp_mem_if.port         mem,
  output logic             m_req_o,
  output logic             m_we_o,
  output logic [31:0]      m_addr_o,
  output logic [31:0]      m_wdata_o,
  input  wire logic        m_ack_i,
  input  wire logic [31:0] m_rdata_i
);
  // Registers the external memory request so the top drives pins from flops.
  logic        next_req;
  logic        next_we;
  logic [31:0] next_addr;
  logic [31:0] next_wdata;

  always_comb begin
    next_req   = m_req_o;
    next_we    = m_we_o;
    next_addr  = m_addr_o;
    next_wdata = m_wdata_o;
    if (m_req_o && m_ack_i) begin
      next_req = 1'b0;
    end else if (!m_req_o && mem.req) begin
      next_req   = 1'b1;
      next_we    = mem.we;
      next_addr  = mem.addr;
      next_wdata = mem.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      m_req_o   <= 1'b0;
      m_we_o    <= 1'b0;
      m_addr_o  <= PRBP_RST_ZERO;
      m_wdata_o <= PRBP_RST_ZERO;
    end else if (clk_en_i) begin
      m_req_o   <= next_req;
      m_we_o    <= next_we;
      m_addr_o  <= next_addr;
      m_wdata_o <= next_wdata;
    end
  end

  assign mem.ack   = m_req_o && m_ack_i;
  assign mem.rdata = m_rdata_i;
endmodule : prbp_mem_port

//--- src/prbp_sync.sv
`timescale 1ns/1ps
module prbp_sync
  import prbp_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic stage1;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= 1'b0;
      q_o    <= 1'b0;
    end else if (clk_en_i) begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule : prbp_sync

//--- src/prbp_top.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
//
// Contract
// - After flags update the device may read the chain and buffers at once.
// - Device may suppress available notifications through its event suppression word.
// - Device sends a used notification after using a descriptor, unless suppressed.
// - Without payload feature, a notification carries only the queue number.
// - Split ring payload: low 15 bits are offset, bit 15 is wrap.
// - Packed ring payload: offset is next descriptor entry, wrap its counter.
// - Device tolerates repeated notifications with identical offset and wrap.
// - Device allocates each shared memory region itself and presents it.
// - Device may offer several regions, each with its own identifier.
// - Shared memory references are offsets from the region start.
// - Device never exposes control or streaming memory as a shared region.
// - Device consumes a descriptor only after seeing its avail marker change.
// - Suppression codes: 0 enabled, 1 disabled, 2 specific descriptor, 3 reserved.
module prbp_top
  import prbp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             m_req_o,
  output logic             m_we_o,
  output logic [31:0]      m_addr_o,
  output logic [31:0]      m_wdata_o,
  input  wire logic        m_ack_i,
  input  wire logic [31:0] m_rdata_i,
  input  wire logic        buf_done_i,
  output logic             desc_valid_o,
  output logic             used_note_o
);
  import prbp_pkg::*;

  // Register address decode, used by read and write paths.
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      PRBP_REG_CTRL, PRBP_REG_RING_BASE, PRBP_REG_RING_SIZE, PRBP_REG_EVT_SUPP,
      PRBP_REG_DOORBELL, PRBP_REG_STATUS, PRBP_REG_LAST_DESC, PRBP_REG_LAST_ID,
      PRBP_REG_USED_CNT, PRBP_REG_DRV_EVT, PRBP_REG_SHM_BASE, PRBP_REG_SHM_SIZE,
      PRBP_REG_NOTE_DATA: mapped = 1'b1;
      default:            mapped = 1'b0;
    endcase
  endfunction : mapped

  prbp_mem_if mem ();

  logic done_sync;

  prbp_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .d_i       (buf_done_i),
    .q_o       (done_sync)
  );

  prbp_mem_port u_mem (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .mem       (mem),
    .m_req_o   (m_req_o),
    .m_we_o    (m_we_o),
    .m_addr_o  (m_addr_o),
    .m_wdata_o (m_wdata_o),
    .m_ack_i   (m_ack_i),
    .m_rdata_i (m_rdata_i)
  );

  // Register state.
  logic [31:0] ctrl;
  logic [31:0] ring_base;
  logic [15:0] ring_size;
  logic [31:0] evt_supp;
  logic [31:0] drv_evt;
  logic [31:0] note_data;
  logic [31:0] last_desc;
  logic [15:0] last_id;
  logic [31:0] used_cnt;
  logic        doorbell_pend;
  logic [31:0] shm_base [PRBP_SHM_REGIONS];
  logic [31:0] shm_size [PRBP_SHM_REGIONS];
  logic [31:0] next_ctrl;
  logic [31:0] next_ring_base;
  logic [15:0] next_ring_size;
  logic [31:0] next_evt_supp;
  logic [31:0] next_drv_evt;
  logic [31:0] next_note_data;
  logic        next_doorbell_pend;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // Engine state.
  prbp_state_t state;
  prbp_state_t next_state;
  logic [14:0] idx;
  logic [14:0] next_idx;
  logic        wrap;
  logic        next_wrap;
  logic [1:0]  word;
  logic [1:0]  next_word;
  logic [31:0] next_last_desc;
  logic [15:0] next_last_id;
  logic [31:0] next_used_cnt;
  logic        next_desc_valid;
  logic        next_used_note;
  logic        mreq;
  logic        mwe;
  logic [31:0] maddr;
  logic [31:0] mwdata;

  logic        access;
  logic        db_write;
  logic [31:0] desc_addr;
  logic        flag_avail;
  logic        flag_used;

  assign access    = psel && penable && !pready;
  assign db_write  = access && pwrite && (paddr == PRBP_REG_DOORBELL);
  assign desc_addr = ring_base + ({17'h0, idx} * PRBP_DESC_BYTES);

  // Shared regions are sized and placed by the device itself, never by software.
  for (genvar r = 0; r < PRBP_SHM_REGIONS; r++) begin : g_shm
    assign shm_base[r] = 32'h0001_0000 * (r + 1);
    assign shm_size[r] = 32'h0000_1000;
  end

  always_comb begin
    next_ctrl          = ctrl;
    next_ring_base     = ring_base;
    next_ring_size     = ring_size;
    next_evt_supp      = evt_supp;
    next_drv_evt       = drv_evt;
    next_note_data     = note_data;
    next_doorbell_pend = doorbell_pend;
    next_prdata        = prdata;
    next_pready        = 1'b0;
    next_pslverr       = 1'b0;
    if (access) begin
      next_pready  = 1'b1;
      next_pslverr = !mapped(paddr);
      if (pwrite) begin
        case (paddr)
          PRBP_REG_CTRL:      next_ctrl      = pwdata;
          PRBP_REG_RING_BASE: next_ring_base = pwdata;
          PRBP_REG_RING_SIZE: next_ring_size = pwdata[15:0];
          PRBP_REG_EVT_SUPP:  next_evt_supp  = pwdata;
          PRBP_REG_DRV_EVT:   next_drv_evt   = pwdata;
          PRBP_REG_DOORBELL: begin
            // Repeated doorbells re-arm polling and reload note_data, so duplicates are harmless.
            next_doorbell_pend = 1'b1;
            if (ctrl[PRBP_CTRL_NOTE_DATA]) begin
              next_note_data = pwdata;
            end else begin
              next_note_data = {16'h0, pwdata[15:0]};
            end
          end
          default: next_note_data = note_data;
        endcase
      end else begin
        case (paddr)
          PRBP_REG_CTRL:      next_prdata = ctrl;
          PRBP_REG_RING_BASE: next_prdata = ring_base;
          PRBP_REG_RING_SIZE: next_prdata = {16'h0, ring_size};
          PRBP_REG_EVT_SUPP:  next_prdata = evt_supp;
          PRBP_REG_STATUS:    next_prdata = {12'h0, wrap, 1'b0, state, idx};
          PRBP_REG_LAST_DESC: next_prdata = last_desc;
          PRBP_REG_LAST_ID:   next_prdata = {16'h0, last_id};
          PRBP_REG_USED_CNT:  next_prdata = used_cnt;
          PRBP_REG_DRV_EVT:   next_prdata = drv_evt;
          PRBP_REG_SHM_BASE:  next_prdata = shm_base[pwdata[0]];
          PRBP_REG_SHM_SIZE:  next_prdata = shm_size[pwdata[0]];
          PRBP_REG_NOTE_DATA: next_prdata = note_data;
          default:            next_prdata = PRBP_RST_ZERO;
        endcase
      end
    end
    if (state == PRBP_POLL && !db_write) begin
      next_doorbell_pend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl          <= PRBP_RST_CTRL;
      ring_base     <= PRBP_RST_ZERO;
      ring_size     <= PRBP_RST_RING_SIZE;
      evt_supp      <= PRBP_RST_ZERO;
      drv_evt       <= PRBP_RST_ZERO;
      note_data     <= PRBP_RST_ZERO;
      doorbell_pend <= 1'b0;
      prdata        <= PRBP_RST_ZERO;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else if (clk_en_i) begin
      ctrl          <= next_ctrl;
      ring_base     <= next_ring_base;
      ring_size     <= next_ring_size;
      evt_supp      <= next_evt_supp;
      drv_evt       <= next_drv_evt;
      note_data     <= next_note_data;
      doorbell_pend <= next_doorbell_pend;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
    end
  end

  assign flag_avail = m_rdata_i[PRBP_FLAG_AVAIL];
  assign flag_used  = m_rdata_i[PRBP_FLAG_USED];

  always_comb begin
    next_state      = state;
    next_idx        = idx;
    next_wrap       = wrap;
    next_word       = word;
    next_last_desc  = last_desc;
    next_last_id    = last_id;
    next_used_cnt   = used_cnt;
    next_desc_valid = 1'b0;
    next_used_note  = 1'b0;
    mreq            = 1'b0;
    mwe             = 1'b0;
    maddr           = desc_addr + PRBP_FLAGS_OFS;
    mwdata          = PRBP_RST_ZERO;
    case (state)
      PRBP_IDLE: begin
        if (ctrl[PRBP_CTRL_ENABLE] && (doorbell_pend || evt_supp[1:0] != PRBP_EVT_ENABLE)) begin
          next_state = PRBP_POLL;
        end
      end
      PRBP_POLL: begin
        // Flags are read first; other fields wait until the marker flips.
        mreq = 1'b1;
        if (mem.ack) begin
          if (flag_avail == wrap && flag_used != wrap) begin
            next_last_id = m_rdata_i[31:16];
            next_word    = 2'h0;
            next_state   = PRBP_FETCH;
          end else begin
            next_state = PRBP_IDLE;
          end
        end
      end
      PRBP_FETCH: begin
        mreq  = 1'b1;
        maddr = desc_addr + {28'h0, next_word, 2'h0};
        if (mem.ack) begin
          if (word == 2'h0) begin
            next_last_desc = m_rdata_i;
          end
          next_word = word + 2'h1;
          if (next_word == PRBP_DESC_WORDS) begin
            next_desc_valid = 1'b1;
            next_state      = PRBP_WORK;
          end
        end
      end
      PRBP_WORK: begin
        if (done_sync) begin
          next_state = PRBP_USED;
        end
      end
      PRBP_USED: begin
        mreq   = 1'b1;
        mwe    = 1'b1;
        mwdata = {16'h0, wrap, 7'h0, wrap, 7'h0};
        if (mem.ack) begin
          next_used_cnt = used_cnt + 32'h1;
          if (drv_evt[1:0] == PRBP_EVT_ENABLE ||
              (drv_evt[1:0] == PRBP_EVT_DESC && drv_evt[30:16] == idx &&
               drv_evt[31] == wrap)) begin
            next_used_note = 1'b1;
          end
          if ({1'b0, idx} + 16'h1 >= ring_size) begin
            next_idx  = 15'h0;
            next_wrap = !wrap;
          end else begin
            next_idx = idx + 15'h1;
          end
          next_state = PRBP_POLL;
        end
      end
      default: next_state = PRBP_IDLE;
    endcase
  end

  assign mem.req   = mreq && !m_req_o;
  assign mem.we    = mwe;
  assign mem.addr  = maddr;
  assign mem.wdata = mwdata;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state        <= PRBP_IDLE;
      idx          <= 15'h0;
      wrap         <= 1'b1;
      word         <= 2'h0;
      last_desc    <= PRBP_RST_ZERO;
      last_id      <= 16'h0;
      used_cnt     <= PRBP_RST_ZERO;
      desc_valid_o <= 1'b0;
      used_note_o  <= 1'b0;
    end else if (clk_en_i) begin
      state        <= next_state;
      idx          <= next_idx;
      wrap         <= next_wrap;
      word         <= next_word;
      last_desc    <= next_last_desc;
      last_id      <= next_last_id;
      used_cnt     <= next_used_cnt;
      desc_valid_o <= next_desc_valid;
      used_note_o  <= next_used_note;
    end
  end
endmodule : prbp_top

//--- dv/prbp_monitor.sv
`timescale 1ns/1ps
module prbp_monitor
  import prbp_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        clk_en_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        m_req_o,
  input wire logic        m_we_o,
  input wire logic [31:0] m_addr_o,
  input wire logic [31:0] m_wdata_o,
  input wire logic        m_ack_i,
  input wire logic        buf_done_i,
  input wire logic        desc_valid_o,
  input wire logic        used_note_o
);
  logic [2:0] rd_cnt;
  logic [2:0] next_rd_cnt;
  logic       wb_seen;
  logic       next_wb_seen;
  logic       done_seen;
  logic       next_done_seen;

  // A saturating count is enough: a fetch needs four reads at the least.
  always_comb begin
    next_rd_cnt    = desc_valid_o ? 3'h0 : rd_cnt;
    next_wb_seen   = wb_seen & ~desc_valid_o & ~used_note_o;
    next_done_seen = (done_seen & ~desc_valid_o) | buf_done_i;
    if (m_req_o && m_ack_i && !m_we_o && rd_cnt != 3'h7) begin
      next_rd_cnt = rd_cnt + 3'h1;
    end
    if (m_req_o && m_ack_i && m_we_o) begin
      next_wb_seen = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_cnt    <= 3'h0;
      wb_seen   <= 1'b0;
      done_seen <= 1'b0;
    end else if (clk_en_i) begin
      rd_cnt    <= next_rd_cnt;
      wb_seen   <= next_wb_seen;
      done_seen <= next_done_seen;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  // A frozen block ignores acks, so handshake checks pause while the enable is low.
  default disable iff (!reset_n_i || !clk_en_i);

  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in one cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_refuse_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_req_held: assert property (m_req_o && !m_ack_i |=> m_req_o && $stable(m_addr_o))
    else $error("memory request changed before ack");
  a_req_release: assert property (m_req_o && m_ack_i |=> !m_req_o)
    else $error("memory request not dropped after ack");
  a_fetch_reads: assert property (desc_valid_o |-> rd_cnt >= 3'h4)
    else $error("descriptor valid before flags and body reads");
  a_valid_pulse: assert property (desc_valid_o |=> !desc_valid_o)
    else $error("descriptor valid longer than one cycle");
  a_marks_equal: assert property (m_req_o && m_we_o |->
    m_wdata_o[PRBP_FLAG_AVAIL] == m_wdata_o[PRBP_FLAG_USED])
    else $error("written back markers differ");
  a_flags_word: assert property (m_req_o && m_we_o |-> m_addr_o[3:0] == 4'hC)
    else $error("write back not aimed at the flags word");
  a_wb_after_done: assert property (m_req_o && m_we_o |-> done_seen)
    else $error("write back before the buffer was finished");
  a_note_after_wb: assert property (used_note_o |-> wb_seen ##1 !used_note_o)
    else $error("used notification without write back");

  c_fetch: cover property (desc_valid_o);
  c_note: cover property (used_note_o);
  c_refuse: cover property (pslverr);
endmodule : prbp_monitor

bind prbp_top prbp_monitor prbp_monitor_inst (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .psel(psel),
  .penable(penable),
  .pready(pready), .pslverr(pslverr), .m_req_o(m_req_o), .m_we_o(m_we_o),
  .m_addr_o(m_addr_o), .m_wdata_o(m_wdata_o), .m_ack_i(m_ack_i),
  .buf_done_i(buf_done_i), .desc_valid_o(desc_valid_o), .used_note_o(used_note_o)
);

//--- dv/prbp_drv_mem.sv
`timescale 1ns/1ps
module prbp_drv_mem
  import prbp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  import prbp_pkg::*;
  logic [31:0] mem [64];
  logic [1:0]  wait_q;
  logic [31:0] last_wr;
  int          num_wr;

  initial for (int i = 0; i < 64; i++) mem[i] = 32'h0000_0000;

  // Ring sits at word 16; the flags word goes last, and no chaining is used.
  task automatic post(input int idx, input logic [31:0] a, input logic [31:0] len,
                      input logic [15:0] id, input logic wr, input logic wrap);
    logic [31:0] f;
    f = {id, 16'h0000};
    f[PRBP_FLAG_WRITABLE] = wr;
    f[PRBP_FLAG_AVAIL] = wrap;
    f[PRBP_FLAG_USED] = ~wrap;
    mem[16 + 4 * idx] = a;
    mem[17 + 4 * idx] = 32'h0000_0000;
    mem[18 + 4 * idx] = len;
    mem[19 + 4 * idx] = f;
  endtask : post

  // Idle read data toggles so that a late sample never sees stale words.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      rdata_o <= 32'h5A5A_A5A5;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      wait_q <= 2'($urandom_range(0, 3));
      if (we_i) begin
        mem[addr_i[7:2]] <= wdata_i;
        last_wr <= wdata_i;
        num_wr <= num_wr + 1;
      end
    end else if (req_i && wait_q == 2'h0) begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i[7:2]];
    end else begin
      wait_q <= wait_q - (req_i ? 2'h1 : 2'h0);
      rdata_o <= ~rdata_o;
    end
  end
endmodule : prbp_drv_mem

//--- dv/packed_ring_buffer_posting_tb.sv
`timescale 1ns/1ps
module packed_ring_buffer_posting_tb;
  import prbp_pkg::*;
  logic        ref_clk_i, reset_n_i, clk_en_i, psel, penable, pwrite, buf_done_i, m_ack_i;
  logic        pready, pslverr, m_req_o, m_we_o, desc_valid_o, used_note_o, e, wrap, quiet;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m_addr_o, m_wdata_o, m_rdata_i, r, d;
  logic [15:0] id;
  int          num_errors, n_tests, cycles, nv, nn, exp_nn, idx;

  prbp_top prbp_top_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_req_o(m_req_o),
    .m_we_o(m_we_o), .m_addr_o(m_addr_o), .m_wdata_o(m_wdata_o), .m_ack_i(m_ack_i),
    .m_rdata_i(m_rdata_i), .buf_done_i(buf_done_i), .desc_valid_o(desc_valid_o),
    .used_note_o(used_note_o));
  prbp_drv_mem prbp_drv_mem_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .req_i(m_req_o), .we_i(m_we_o), .addr_i(m_addr_o), .wdata_i(m_wdata_o),
    .ack_o(m_ack_i), .rdata_o(m_rdata_i));

  function automatic logic [31:0] note_exp(input logic feat, input logic [31:0] v);
    return feat ? v : {16'h0000, v[15:0]};
  endfunction : note_exp

  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  // The request is held until pready is sampled high, for at most 64 cycles; a timeout counts as an error.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rv, output logic ev);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) num_errors++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rv;
    logic        ev;
    apb(1'b1, a, wd, rv, ev);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rv;
    logic        ev;
    apb(1'b0, a, 32'h0000_0000, rv, ev);
    chk(nm, rv, exp);
  endtask : rd_chk

  task automatic wait_cnt(input int tv, input int tn, input int tw, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (nv >= tv && nn >= tn && prbp_drv_mem_inst.num_wr >= tw) break;
      @(posedge ref_clk_i);
    end
  endtask : wait_cnt

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (desc_valid_o === 1'b1) nv <= nv + 1;
    if (used_note_o === 1'b1) nn <= nn + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    {reset_n_i, psel, penable, pwrite, buf_done_i, paddr, pwdata} = '0;
    clk_en_i = 1'b1;
    d = $urandom(32'h8D11_0C2E);
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd_chk("ctrl", PRBP_REG_CTRL, PRBP_RST_CTRL);
    rd_chk("ring_size", PRBP_REG_RING_SIZE, {16'h0000, PRBP_RST_RING_SIZE});
    rd_chk("status", PRBP_REG_STATUS, 32'h0008_0000);
    rd_chk("evt_supp", PRBP_REG_EVT_SUPP, PRBP_RST_ZERO);
    apb(1'b0, 12'h0FC, 32'h0000_0000, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
    chk("unmapped_data", r, 32'h0000_0000);
    for (int f = 0; f < 2; f++) begin
      d = $urandom();
      wr(PRBP_REG_CTRL, {29'h0, 1'b1, f[0], 1'b0});
      repeat (2) begin
        wr(PRBP_REG_DOORBELL, d);
        rd_chk("note_data", PRBP_REG_NOTE_DATA, note_exp(f[0], d));
      end
    end
    // The ring is still all zero, so nothing may be consumed.
    wr(PRBP_REG_RING_BASE, 32'h0000_0040);
    wr(PRBP_REG_RING_SIZE, 32'h0000_0002);
    wr(PRBP_REG_CTRL, 32'h0000_0007);
    wr(PRBP_REG_DOORBELL, 32'h0000_8000);
    repeat (40) @(posedge ref_clk_i);
    chk("early_fetch", 32'(nv), 32'h0000_0000);
    wrap = 1'b1;
    idx = 0;
    for (int k = 0; k < 4; k++) begin
      id = 16'($urandom());
      quiet = k[0];
      exp_nn += quiet ? 0 : 1;
      wr(PRBP_REG_DRV_EVT, {31'h0, quiet});
      if (!quiet) rd_chk("used_cnt", PRBP_REG_USED_CNT, 32'(k));
      if (k == 2) wr(PRBP_REG_EVT_SUPP, {30'h0, PRBP_EVT_DISABLE});
      prbp_drv_mem_inst.post(idx, $urandom(), $urandom(), id, 1'($urandom()), wrap);
      apb(1'b0, PRBP_REG_EVT_SUPP, 32'h0000_0000, r, e);
      if (r[1:0] != PRBP_EVT_DISABLE) begin
        wr(PRBP_REG_DOORBELL, {16'h0000, wrap ^ (idx == 1), 15'(idx == 0)});
      end
      wait_cnt(k + 1, 0, 0, 400);
      chk("fetched", 32'(nv), 32'(k + 1));
      rd_chk("last_id", PRBP_REG_LAST_ID, {16'h0000, id});
      buf_done_i <= 1'b1;
      wait_cnt(0, exp_nn + (quiet ? 1 : 0), k + 1, quiet ? 16 : 400);
      buf_done_i <= 1'b0;
      chk("used_note", 32'(nn), 32'(exp_nn));
      r = prbp_drv_mem_inst.last_wr;
      chk("wb_marks", {30'h0, r[PRBP_FLAG_USED], r[PRBP_FLAG_AVAIL]},
          {30'h0, wrap, wrap});
      if (idx == 1) begin
        idx = 0;
        wrap = ~wrap;
      end else begin
        idx++;
      end
    end
    clk_en_i <= 1'b0;
    @(posedge ref_clk_i);
    d = {m_addr_o[30:0], m_req_o};
    repeat (8) begin
      @(posedge ref_clk_i);
      chk("frozen", {m_addr_o[30:0], m_req_o}, d);
    end
    clk_en_i <= 1'b1;
    apb(1'b0, PRBP_REG_STATUS, 32'h0000_0000, r, e);
    chk("status_wrap", {31'h0, r[19]}, {31'h0, wrap});
    final_report();
  end
endmodule : packed_ring_buffer_posting_tb
